// ===== rtl/cdfc_top.sv
/*
 * communication diagnostics: per-link byte and init-byte error detection,
 * byte suppression until resync, fault flag groups, saturating frame and
 * discard counters with snapshot on a read of each link's key register.
 * assumes the receive front ends deliver one decoded byte per pulse,
 * synchronous to clock, and a frame parser that reports frame end and crc.
 * limitation: a read of a key register returns the snapshot taken by the
 * previous key read; the fresh snapshot shows in the other counter words.
 * counters are single 16-bit and 8-bit words, not byte pairs, so a snapshot
 * can be read without tearing between halves.
 */
// Operation
// - separate link, response, command and transmit fault groups for each link
// - after a byte error ignore bytes until break (host) or sof byte (chain)
// - byte and init-byte error flags clear only by communication clear, a clear register write or reset
// - chain port sets byte error flag when any frame byte carries a byte error
// - host sets byte error on stop error not directly followed by a break
// - ignored chain bytes still forward; ignored host bytes are not propagated
// - no further frame errors, crc included, are flagged while ignoring
// - chain init-byte error: first byte lacks sof or has reserved frame type
// - host init-byte error: stop error, reserved bits, or response outside multidrop
// - multidrop: response as first frame after break is an init-byte error
// - host first byte is the byte after a break or after frame end
// - per link 16-bit counters of transmitted, response and command frames
// - per link 8-bit counters of discarded response and command frames
// - all counters saturate at maximum and never wrap
// - key register read snapshots all counters of its own link and zeroes them
// - each later key read snapshots again and zeroes again
// - chain transmit counter counts only self generated responses
// - response counter counts each error free response, stack reads included
// - forwarded single device responses do not count as received responses
// - command counter counts each error free command frame
// - response discard counts dropped responses except on init-byte error
// - command discard counts dropped commands except on init-byte error
// - discard cause is flagged in the same cycle the discard is counted
// - chain byte with reception error is forwarded with its byte error bit set
// - chain sof byte starts a new frame like a host break
`timescale 1ns/1ps
`default_nettype none

module cdfc_top
	import cdfc_pkg::*;
(
	input  wire logic                   clock,
	input  wire logic                   rstn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic                        pready,
	output logic [31:0]                 prdata,
	output logic                        pslverr,
	input  wire logic [NLINK-1:0]       rx_byte_vld,
	input  wire logic [NLINK-1:0][7:0]  rx_byte_data,
	input  wire logic [NLINK-1:0]       rx_byte_sof,
	input  wire logic [NLINK-1:0]       rx_byte_err,
	input  wire logic [NLINK-1:0]       rx_first_bad,
	input  wire logic [NLINK-1:0]       rx_first_resp,
	input  wire logic [NLINK-1:0]       rx_break,
	input  wire logic [NLINK-1:0]       frame_end,
	input  wire logic [NLINK-1:0]       frame_ok,
	input  wire logic [NLINK-1:0]       frame_fwd_only,
	input  wire logic [NLINK-1:0]       tx_gen_done,
	input  wire logic [NLINK-1:0]       tx_fault,
	output logic [NLINK-1:0]            fwd_vld,
	output logic [NLINK-1:0][7:0]       fwd_data,
	output logic [NLINK-1:0]            fwd_byte_error_flag,
	output logic [NLINK-1:0]            ignoring
);

	// ==========================================================
	// helpers
	function automatic logic [15:0] sat16(input logic [15:0] v);
		return (v == CNT16_MAX) ? v : v + CNT16_ONE;
	endfunction

	function automatic logic [7:0] sat8(input logic [7:0] v);
		return (v == CNT8_MAX) ? v : v + CNT8_ONE;
	endfunction

	cdfc_state_t q;
	cdfc_state_t d;

	// ==========================================================
	// next state
	always_comb
	begin
		logic [1:0] blk;
		logic [3:0] wrd;
		logic       hit;
		logic       done;
		logic       chain;
		logic       resync;
		logic       live;
		logic       first;
		logic       init_byte_error_flag;
		logic       byte_error_flag_now;
		logic       byte_error_flag_resp;
		logic       key_rd;
		logic [31:0] rd;
		d = q;
		blk = paddr[7:6];
		wrd = paddr[5:2];
		hit = 1'b0;
		rd = '0;
		chain = 1'b0;
		resync = 1'b0;
		live = 1'b0;
		first = 1'b0;
		init_byte_error_flag = 1'b0;
		byte_error_flag_now = 1'b0;
		byte_error_flag_resp = 1'b0;
		key_rd = 1'b0;
		done = psel & penable & q.pready;

		// apb: one wait state, read data taken from the registered mux
		// error strobe stands for the ack cycle only, like pready
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		if (blk == LINK_GLOBAL)
		begin
			hit = (wrd == REG_CTRL);
			rd[CTRL_MULTIDROP_BIT] = q.multidrop;
		end
		else
		begin
			hit = (wrd <= REG_CLEAR);
			case (wrd)
				REG_LINK_FLT: rd[7:0] = q.flt_link[blk];
				REG_RR_FLT:   rd[7:0] = q.flt_rr[blk];
				REG_RC_FLT:   rd[7:0] = q.flt_rc[blk];
				REG_TR_FLT:   rd[7:0] = q.flt_tr[blk];
				REG_TX_CNT:   rd[15:0] = q.tx_snap[blk];
				REG_RR_CNT:   rd[15:0] = q.rr_snap[blk];
				REG_RC_CNT:   rd[15:0] = q.rc_snap[blk];
				REG_RD_CNT:   rd[7:0] = q.rd_snap[blk];
				REG_CD_CNT:   rd[7:0] = q.cd_snap[blk];
				default:      rd = '0;
			endcase
		end
		if (psel & penable & ~q.pready)
		begin
			d.pready = 1'b1;
			d.pslverr = ~hit;
			d.prdata = (pwrite | ~hit) ? '0 : rd;
		end
		if (done & pwrite & hit & (blk == LINK_GLOBAL))
		begin
			d.multidrop = pwdata[CTRL_MULTIDROP_BIT];
		end

		for (int i = 0; i < NLINK; i++)
		begin
			chain = (i != LINK_HOST);
			init_byte_error_flag = 1'b0;
			first = 1'b0;
			byte_error_flag_now = 1'b0;
			byte_error_flag_resp = q.resp[i];
			d.fwd_vld[i] = 1'b0;
			d.fwd_byte_error_flag[i] = 1'b0;

			// ==========================================================
			// software clear of the link's flags; a set below still wins
			if (done & pwrite & (blk == 2'(i)) & (wrd == REG_CLEAR)
				& pwdata[CLEAR_FLAGS_BIT])
			begin
				d.flt_link[i] = '0;
				d.flt_rr[i] = '0;
				d.flt_rc[i] = '0;
				d.flt_tr[i] = '0;
			end

			// ==========================================================
			// key read: snapshot then zero; this cycle's events land in the fresh count
			key_rd = done & ~pwrite & (blk == 2'(i))
				& (wrd == ((i == LINK_HIGH) ? REG_RD_CNT : REG_CD_CNT));
			if (key_rd)
			begin
				d.tx_snap[i] = q.tx_cnt[i];
				d.rr_snap[i] = q.rr_cnt[i];
				d.rc_snap[i] = q.rc_cnt[i];
				d.rd_snap[i] = q.rd_cnt[i];
				d.cd_snap[i] = q.cd_cnt[i];
				d.tx_cnt[i] = '0;
				d.rr_cnt[i] = '0;
				d.rc_cnt[i] = '0;
				d.rd_cnt[i] = '0;
				d.cd_cnt[i] = '0;
			end

			// ==========================================================
			// resynchronisation: host break, or chain byte with sof
			resync = chain ? (rx_byte_vld[i] & rx_byte_sof[i]) : rx_break[i];
			if (~chain & rx_break[i])
			begin
				// communication clear: drops a pending stop error, clears byte and init-byte error flags
				d.pend[i] = 1'b0;
				d.ign[i] = 1'b0;
				d.flt_rr[i][FLT_BYTE_ERROR_FLAG_BIT] = 1'b0;
				d.flt_rc[i][FLT_BYTE_ERROR_FLAG_BIT] = 1'b0;
				d.flt_rc[i][FLT_INIT_BYTE_ERROR_FLAG_BIT] = 1'b0;
				d.expect_first[i] = 1'b1;
				d.after_brk[i] = 1'b1;
				d.in_frame[i] = 1'b0;
			end
			if (chain & resync)
			begin
				d.ign[i] = 1'b0;
				if (q.in_frame[i] & ~q.ign[i])
				begin
					// sof inside a frame drops that frame
					d.flt_link[i][FLT_SOF_BIT] = 1'b1;
					if (q.resp[i])
						d.rd_cnt[i] = sat8(d.rd_cnt[i]);
					else
						d.cd_cnt[i] = sat8(d.cd_cnt[i]);
				end
				d.in_frame[i] = 1'b0;
			end
			live = ~(q.ign[i] & ~(chain & resync));

			// ==========================================================
			// interface level: any received byte with a reception error
			if (rx_byte_vld[i] & rx_byte_err[i])
				d.flt_link[i][FLT_RXERR_BIT] = 1'b1;

			// ==========================================================
			// host stop error resolves on the next byte, unless a break came first
			if (~chain & q.pend[i] & rx_byte_vld[i] & ~rx_break[i])
			begin
				d.pend[i] = 1'b0;
				byte_error_flag_now = 1'b1;
			end

			// ==========================================================
			// byte checks: first byte of a frame, then errors inside it
			if (rx_byte_vld[i] & live & ~q.pend[i])
			begin
				first = chain ? (rx_byte_sof[i] | q.expect_first[i]) : q.expect_first[i];
				if (first)
				begin
					if (chain)
						init_byte_error_flag = ~rx_byte_sof[i] | rx_first_bad[i];
					else
						init_byte_error_flag = rx_byte_err[i] | rx_first_bad[i]
							| (rx_first_resp[i] & ~q.multidrop)
							| (rx_first_resp[i] & q.multidrop
								& q.after_brk[i]);
					if (init_byte_error_flag)
					begin
						// init errors are flagged but never counted as discards
						d.flt_rc[i][FLT_INIT_BYTE_ERROR_FLAG_BIT] = 1'b1;
						d.ign[i] = 1'b1;
						d.in_frame[i] = 1'b0;
					end
					else if (chain & rx_byte_err[i])
					begin
						// a damaged init byte opens no frame; its type picks the group
						d.ign[i] = 1'b1;
						d.in_frame[i] = 1'b0;
						byte_error_flag_now = 1'b1;
						byte_error_flag_resp = rx_first_resp[i];
					end
					else
					begin
						d.in_frame[i] = 1'b1;
						d.resp[i] = rx_first_resp[i];
						d.expect_first[i] = 1'b0;
						d.after_brk[i] = 1'b0;
					end
				end
				else if (rx_byte_err[i])
				begin
					d.ign[i] = 1'b1;
					if (chain)
						byte_error_flag_now = 1'b1;
					else
						d.pend[i] = 1'b1;
				end
			end

			// ==========================================================
			// byte error: flag and discard count in the same cycle
			if (byte_error_flag_now)
			begin
				if (byte_error_flag_resp)
					d.flt_rr[i][FLT_BYTE_ERROR_FLAG_BIT] = 1'b1;
				else
					d.flt_rc[i][FLT_BYTE_ERROR_FLAG_BIT] = 1'b1;
				// a frame cut short by a sof was counted above; count it once
				if (q.in_frame[i] & ~first & byte_error_flag_resp)
					d.rd_cnt[i] = sat8(d.rd_cnt[i]);
				else if (q.in_frame[i] & ~first)
					d.cd_cnt[i] = sat8(d.cd_cnt[i]);
				d.in_frame[i] = 1'b0;
			end

			// ==========================================================
			// frame end from the parser; ignored while suppressing bytes
			if (frame_end[i] & ~q.ign[i] & q.in_frame[i] & ~byte_error_flag_now & ~resync)
			begin
				d.in_frame[i] = 1'b0;
				d.expect_first[i] = 1'b1;
				if (frame_ok[i] & q.resp[i] & ~frame_fwd_only[i])
					d.rr_cnt[i] = sat16(d.rr_cnt[i]);
				else if (frame_ok[i] & ~q.resp[i])
					d.rc_cnt[i] = sat16(d.rc_cnt[i]);
				else if (~frame_ok[i] & q.resp[i])
				begin
					d.flt_rr[i][FLT_FRAME_BIT] = 1'b1;
					d.rd_cnt[i] = sat8(d.rd_cnt[i]);
				end
				else if (~frame_ok[i])
				begin
					d.flt_rc[i][FLT_FRAME_BIT] = 1'b1;
					d.cd_cnt[i] = sat8(d.cd_cnt[i]);
				end
			end

			// ==========================================================
			// transmit side: only frames this device generated are counted
			if (tx_gen_done[i])
				d.tx_cnt[i] = sat16(d.tx_cnt[i]);
			if (tx_fault[i])
				d.flt_tr[i][FLT_TXERR_BIT] = 1'b1;

			// ==========================================================
			// forwarding: chain bytes always go on, tagged when suspect
			d.fwd_data[i] = rx_byte_data[i];
			if (chain)
			begin
				d.fwd_vld[i] = rx_byte_vld[i];
				d.fwd_byte_error_flag[i] = rx_byte_vld[i]
					& (rx_byte_err[i] | ~live);
			end
			else
			begin
				d.fwd_vld[i] = rx_byte_vld[i] & live & ~q.pend[i]
					& ~rx_byte_err[i] & ~init_byte_error_flag;
				d.fwd_byte_error_flag[i] = 1'b0;
			end
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			q <= '0;
			// links start out waiting for a frame's first byte
			q.expect_first <= EXPECT_FIRST_RST;
		end
		else
		begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs
	assign pready = q.pready;
	assign prdata = q.prdata;
	assign pslverr = q.pslverr;
	assign fwd_vld = q.fwd_vld;
	assign fwd_data = q.fwd_data;
	assign fwd_byte_error_flag = q.fwd_byte_error_flag;
	assign ignoring = q.ign;

endmodule // cdfc_top

`default_nettype wire

// ===== inc/cdfc_pkg.sv
/*
 * constants, register map and state type of the communication diagnostics
 * block (fault flags and frame counters for the host serial link and the
 * low and high chain ports).
 * assumes a 40 MHz device clock and an apb master with 32-bit data.
 */
package cdfc_pkg;

	// ==========================================================
	// links
	localparam int NLINK = 3;
	localparam int LINK_HOST = 0;
	localparam int LINK_LOW = 1;
	localparam int LINK_HIGH = 2;

	// ==========================================================
	// register map: link block at paddr[7:6], word at paddr[5:2]
	localparam logic [1:0] LINK_GLOBAL = 2'h3;
	localparam logic [3:0] REG_LINK_FLT = 4'h0;
	localparam logic [3:0] REG_RR_FLT = 4'h1;
	localparam logic [3:0] REG_RC_FLT = 4'h2;
	localparam logic [3:0] REG_TR_FLT = 4'h3;
	localparam logic [3:0] REG_TX_CNT = 4'h4;
	localparam logic [3:0] REG_RR_CNT = 4'h5;
	localparam logic [3:0] REG_RC_CNT = 4'h6;
	localparam logic [3:0] REG_RD_CNT = 4'h7;
	localparam logic [3:0] REG_CD_CNT = 4'h8;
	localparam logic [3:0] REG_CLEAR = 4'h9;
	localparam logic [3:0] REG_CTRL = 4'h0;

	// ==========================================================
	// fields
	localparam int CTRL_MULTIDROP_BIT = 0;
	localparam int CLEAR_FLAGS_BIT = 0;
	localparam int FLT_BYTE_ERROR_FLAG_BIT = 0;
	localparam int FLT_INIT_BYTE_ERROR_FLAG_BIT = 1;
	localparam int FLT_FRAME_BIT = 2;
	localparam int FLT_RXERR_BIT = 0;
	localparam int FLT_SOF_BIT = 1;
	localparam int FLT_TXERR_BIT = 0;

	localparam logic [15:0] CNT16_MAX = 16'hffff;
	localparam logic [7:0] CNT8_MAX = 8'hff;
	localparam logic [15:0] CNT16_ONE = 16'h0001;
	localparam logic [7:0] CNT8_ONE = 8'h01;
	localparam logic [NLINK-1:0] EXPECT_FIRST_RST = 3'h7;

	// ==========================================================
	// state
	typedef struct packed {
		logic                        pready;
		logic                        pslverr;
		logic [31:0]                 prdata;
		logic                        multidrop;
		logic [NLINK-1:0]            ign;
		logic [NLINK-1:0]            pend;
		logic [NLINK-1:0]            expect_first;
		logic [NLINK-1:0]            after_brk;
		logic [NLINK-1:0]            in_frame;
		logic [NLINK-1:0]            resp;
		logic [NLINK-1:0][7:0]       flt_link;
		logic [NLINK-1:0][7:0]       flt_rr;
		logic [NLINK-1:0][7:0]       flt_rc;
		logic [NLINK-1:0][7:0]       flt_tr;
		logic [NLINK-1:0][15:0]      tx_cnt;
		logic [NLINK-1:0][15:0]      rr_cnt;
		logic [NLINK-1:0][15:0]      rc_cnt;
		logic [NLINK-1:0][7:0]       rd_cnt;
		logic [NLINK-1:0][7:0]       cd_cnt;
		logic [NLINK-1:0][15:0]      tx_snap;
		logic [NLINK-1:0][15:0]      rr_snap;
		logic [NLINK-1:0][15:0]      rc_snap;
		logic [NLINK-1:0][7:0]       rd_snap;
		logic [NLINK-1:0][7:0]       cd_snap;
		logic [NLINK-1:0]            fwd_vld;
		logic [NLINK-1:0]            fwd_byte_error_flag;
		logic [NLINK-1:0][7:0]       fwd_data;
	} cdfc_state_t;

endpackage

// ===== dv/cdfc_link_model.sv
/*
 * far-side model of the three links: byte source, break, frame verdicts
 * and transmit events, one pulse per task call.
 * assumes its tasks are called from one process at a time.
 */
`timescale 1ns/1ps
`default_nettype none

module cdfc_link_model
	import cdfc_pkg::*;
(
	input  wire logic              clock,
	output logic [NLINK-1:0]       rx_byte_vld,
	output logic [NLINK-1:0][7:0]  rx_byte_data,
	output logic [NLINK-1:0]       rx_byte_sof,
	output logic [NLINK-1:0]       rx_byte_err,
	output logic [NLINK-1:0]       rx_first_bad,
	output logic [NLINK-1:0]       rx_first_resp,
	output logic [NLINK-1:0]       rx_break,
	output logic [NLINK-1:0]       frame_end,
	output logic [NLINK-1:0]       frame_ok,
	output logic [NLINK-1:0]       frame_fwd_only,
	output logic [NLINK-1:0]       tx_gen_done,
	output logic [NLINK-1:0]       tx_fault
);
	// ==========================================================
	// pulses
	initial
	begin
		{rx_byte_vld, rx_byte_data, rx_byte_sof, rx_byte_err, rx_first_bad} = '0;
		{rx_first_resp, rx_break, frame_end, frame_ok, frame_fwd_only} = '0;
		{tx_gen_done, tx_fault} = '0;
	end

	// f = {sof, err, reserved, response}; released lines show the inverse, not stale data
	task automatic put(input int l, input logic [7:0] d, input logic [3:0] f);
		@(posedge clock);
		rx_byte_vld[l] <= 1'b1;
		rx_byte_data[l] <= d;
		{rx_byte_sof[l], rx_byte_err[l], rx_first_bad[l], rx_first_resp[l]} <= f;
		@(posedge clock);
		rx_byte_vld[l] <= 1'b0;
		rx_byte_data[l] <= ~d;
		{rx_byte_sof[l], rx_byte_err[l], rx_first_bad[l], rx_first_resp[l]} <= ~f;
	endtask

	// k: 0 break, 1 frame end, 2 own response sent, 3 transmit fault; q = {ok, forwarded}
	task automatic ev(input int l, input int k, input logic [1:0] q);
		@(posedge clock);
		{frame_ok[l], frame_fwd_only[l]} <= q;
		rx_break[l] <= (k == 0);
		frame_end[l] <= (k == 1);
		tx_gen_done[l] <= (k == 2);
		tx_fault[l] <= (k == 3);
		@(posedge clock);
		{rx_break[l], frame_end[l], tx_gen_done[l], tx_fault[l]} <= 4'h0;
		{frame_ok[l], frame_fwd_only[l]} <= ~q;
	endtask
endmodule // cdfc_link_model

`default_nettype wire

// ===== dv/cdfc_top_checker.sv
/*
 * port assertions of the diagnostics block.
 * assumes one clock and the async active-low reset rstn.
 */
`timescale 1ns/1ps
`default_nettype none

module cdfc_top_checker
	import cdfc_pkg::*;
(
	input wire logic             clock,
	input wire logic             rstn,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pready,
	input wire logic             pslverr,
	input wire logic [NLINK-1:0] rx_byte_vld,
	input wire logic [NLINK-1:0] rx_byte_sof,
	input wire logic [NLINK-1:0] rx_byte_err,
	input wire logic [NLINK-1:0] rx_first_bad,
	input wire logic [NLINK-1:0][7:0] rx_byte_data,
	input wire logic [NLINK-1:0][7:0] fwd_data,
	input wire logic [NLINK-1:0] rx_break,
	input wire logic [NLINK-1:0] fwd_vld,
	input wire logic [NLINK-1:0] fwd_byte_error_flag,
	input wire logic [NLINK-1:0] ignoring
);
	// ==========================================================
	// properties
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	AST_ACK_WAIT:
		assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("ack not in second access cycle");
	AST_ACK_ONE:
		assert property (pready |=> !pready)
		else $error("ack held too long");
	AST_ERR_ACK:
		assert property (pslverr |-> pready)
		else $error("error without ack");
	AST_HOST_IGN:
		assert property (rx_byte_vld[0] && rx_byte_err[0] |=> ignoring[0])
		else $error("host not ignoring");
	AST_BRK_SYNC:
		assert property (rx_break[0] && !rx_byte_vld[0] |=> !ignoring[0])
		else $error("break did not resync");
	AST_HOST_DROP:
		assert property (ignoring[0] && rx_byte_vld[0] |=> !fwd_vld[0])
		else $error("ignored host byte forwarded");
	AST_CHAIN_IGN:
		assert property (rx_byte_vld[1] && rx_byte_err[1] && !rx_byte_sof[1] |=> ignoring[1])
		else $error("chain not ignoring");
	AST_SOF_SYNC:
		assert property (rx_byte_vld[1] && rx_byte_sof[1] && !rx_byte_err[1]
			&& !rx_first_bad[1] |=> !ignoring[1])
		else $error("sof did not resync");
	AST_FWD_DATA:
		assert property (|fwd_vld |-> fwd_data == $past(rx_byte_data))
		else $error("forwarded byte differs from received byte");
	AST_CHAIN_FWD:
		assert property (rx_byte_vld[2] |=> fwd_vld[2] && (fwd_byte_error_flag[2] || !$past(rx_byte_err[2])))
		else $error("chain byte not forwarded or untagged");
	AST_RST_IDLE:
		assert property ($rose(rstn) |-> !pready && !pslverr && fwd_vld == '0 && ignoring == '0)
		else $error("outputs not idle after reset");

	COV_REFUSE: cover property (pready && pslverr);
	COV_RESYNC: cover property (ignoring[0] && rx_break[0]);
	COV_TAGGED: cover property (fwd_vld[1] && fwd_byte_error_flag[1]);
endmodule // cdfc_top_checker

bind cdfc_top cdfc_top_checker u_chk (
	.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .rx_byte_vld(rx_byte_vld), .rx_byte_sof(rx_byte_sof),
	.rx_byte_err(rx_byte_err), .rx_first_bad(rx_first_bad), .rx_byte_data(rx_byte_data),
	.fwd_data(fwd_data), .rx_break(rx_break), .fwd_vld(fwd_vld),
	.fwd_byte_error_flag(fwd_byte_error_flag), .ignoring(ignoring)
);

`default_nettype wire

// ===== dv/cdfc_tb_top.sv
/*
 * bench of the diagnostics block: apb master, link traffic via the model,
 * flag and counter checks. assumes package, design, model and checker.
 */
`timescale 1ns/1ps
`default_nettype none

module cdfc_tb_top
	import cdfc_pkg::*;
;
	localparam logic [7:0] CTRL_AD = {LINK_GLOBAL, REG_CTRL, 2'h0};
	logic                  clock, rstn, psel, penable, pwrite, pready, pslverr, erv;
	logic [7:0]            paddr;
	logic [31:0]           pwdata, prdata, rdv;
	logic [NLINK-1:0]      rx_byte_vld, rx_byte_sof, rx_byte_err, rx_first_bad, rx_first_resp;
	logic [NLINK-1:0]      rx_break, frame_end, frame_ok, frame_fwd_only, tx_gen_done;
	logic [NLINK-1:0]      tx_fault, fwd_vld, fwd_byte_error_flag, ignoring;
	logic [NLINK-1:0][7:0] rx_byte_data, fwd_data;
	int                    err_count, tests_run, cyc, nc, nr, nt;

	cdfc_top u_dut (
		.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.rx_byte_vld(rx_byte_vld), .rx_byte_data(rx_byte_data), .rx_byte_sof(rx_byte_sof),
		.rx_byte_err(rx_byte_err), .rx_first_bad(rx_first_bad), .rx_first_resp(rx_first_resp),
		.rx_break(rx_break), .frame_end(frame_end), .frame_ok(frame_ok),
		.frame_fwd_only(frame_fwd_only), .tx_gen_done(tx_gen_done), .tx_fault(tx_fault),
		.fwd_vld(fwd_vld), .fwd_data(fwd_data), .fwd_byte_error_flag(fwd_byte_error_flag), .ignoring(ignoring)
	);
	cdfc_link_model u_lnk (
		.clock(clock), .rx_byte_vld(rx_byte_vld), .rx_byte_data(rx_byte_data),
		.rx_byte_sof(rx_byte_sof), .rx_byte_err(rx_byte_err), .rx_first_bad(rx_first_bad),
		.rx_first_resp(rx_first_resp), .rx_break(rx_break), .frame_end(frame_end),
		.frame_ok(frame_ok), .frame_fwd_only(frame_fwd_only), .tx_gen_done(tx_gen_done),
		.tx_fault(tx_fault)
	);

	// ==========================================================
	// clock, timeout, helpers
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// whole run is a few thousand cycles
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_count++;
			finish_test();
		end
	end

	function automatic logic [7:0] ad(input int l, input int w);
		return 8'(l * 64 + w * 4);
	endfunction

	function automatic logic [7:0] key(input int l);
		return ad(l, (l == LINK_HIGH) ? 7 : 8);
	endfunction

	function automatic logic [31:0] sat8(input int n);
		return (n > 255) ? 32'h0000_00ff : 32'(n);
	endfunction

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, s, e);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// only the bench timeout ends this wait
		do
			@(posedge clock);
		while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdv, e);
		chk({31'h0, erv}, 32'h0);
	endtask

	// first byte carries sof (ignored on host), random body, then the verdict
	task automatic frm(input int l, input logic resp, input logic [1:0] q);
		int n;
		n = $urandom_range(3, 0);
		u_lnk.put(l, 8'($urandom), {3'h4, resp});
		repeat (n) u_lnk.put(l, 8'($urandom), 4'h0);
		u_lnk.ev(l, 1, q);
	endtask

	task automatic finish_test();
		if (err_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ==========================================================
	// scenarios
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, rstn} = '0;
		err_count = 0;
		tests_run = 0;
		cyc = 0;
		void'($urandom(63));
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		for (int l = 0; l < NLINK; l++)
			for (int w = 0; w < 9; w++)
				rd(ad(l, w), 32'h0);
		for (int l = 0; l < NLINK; l++)
		begin
			nc = $urandom_range(4, 1);
			nr = (l == LINK_HOST) ? 0 : $urandom_range(4, 1);
			nt = $urandom_range(4, 1);
			repeat (nc) frm(l, 1'b0, 2'b10);
			repeat (nr) frm(l, 1'b1, 2'b10);
			if (l != LINK_HOST)
				frm(l, 1'b1, 2'b11);
			frm(l, 1'b0, 2'b00);
			repeat (nt) u_lnk.ev(l, 2, 2'b00);
			u_lnk.ev(l, 3, 2'b00);
			rd(ad(l, 2), 32'h4);
			rd(ad(l, 3), 32'h1);
			rd(key(l), 32'h0);
			rd(ad(l, 4), 32'(nt));
			rd(ad(l, 5), 32'(nr));
			rd(ad(l, 6), 32'(nc));
			rd(ad(l, 8), 32'h1);
			rd(key(l), 32'h0);
			rd(ad(l, 6), 32'h0);
			apb(1'b1, ad(l, 9), 32'h1);
			rd(ad(l, 2), 32'h0);
		end
		// host: stop error, ignored byte, crc failure while ignoring, break
		for (int i = 0; i < 260; i++)
		begin
			u_lnk.put(LINK_HOST, 8'($urandom), 4'h8);
			u_lnk.put(LINK_HOST, 8'($urandom), 4'h4);
			u_lnk.put(LINK_HOST, 8'($urandom), 4'h0);
			u_lnk.ev(LINK_HOST, 1, 2'b00);
			if (i == 0)
				rd(ad(LINK_HOST, 2), 32'h1);
			u_lnk.ev(LINK_HOST, 0, 2'b00);
		end
		rd(key(LINK_HOST), 32'h0);
		rd(ad(LINK_HOST, 6), 32'h0);
		rd(ad(LINK_HOST, 2), 32'h0);
		rd(key(LINK_HOST), sat8(260));
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, CTRL_AD, 32'(i == 1));
			if (i == 1)
				rd(CTRL_AD, 32'h1);
			u_lnk.ev(LINK_HOST, 0, 2'b00);
			u_lnk.put(LINK_HOST, 8'($urandom), (i < 2) ? 4'h1 : (i == 2) ? 4'h2 : 4'h4);
			rd(ad(LINK_HOST, 2), 32'h2);
		end
		rd(key(LINK_HOST), 32'h0);
		rd(key(LINK_HOST), 32'h0);
		for (int l = 1; l < NLINK; l++)
		begin
			u_lnk.put(l, 8'($urandom), 4'h8);
			u_lnk.put(l, 8'($urandom), 4'h4);
			rd(ad(l, 2), 32'h1);
			u_lnk.put(l, 8'($urandom), 4'h8);
			u_lnk.ev(l, 1, 2'b10);
			apb(1'b1, ad(l, 9), 32'h1);
			u_lnk.put(l, 8'($urandom), (l == 1) ? 4'h0 : 4'ha);
			rd(ad(l, 2), 32'h2);
			u_lnk.put(l, 8'($urandom), 4'hc);
			rd(ad(l, 2), 32'h3);
		end
		apb(1'b0, 8'hd0, 32'h0);
		chk({31'h0, erv}, 32'h1);
		chk(rdv, 32'h0);
		finish_test();
	end
endmodule // cdfc_tb_top

`default_nettype wire
